// [logic/deicr_regs.sv]
// Operation
// - write bits 15-12 select, 11-0 store
// - read index chooses readback sub-register
// - height count is eleven bits, plus one
// - selector 1 holds clip minimum Y
// - selector 2 holds clip minimum X
// - selector 3 holds clip maximum Y
// - selector 4 holds clip maximum X
// - horizontal field sets interleave divisor
// - vertical field sets Y divisor, banks
// - vertical 00 enters pseudo mode unless eight-plane flag set, nonzero leaves
// - buffer select picks lower or upper planes in pseudo mode
// - flash select and enable start flash write
// - colour cycle and enable write colour register
// - masks pick mix by nugget parity
// - mask bit 4 is leftmost pixel
// - pattern writes fill array via counter
// - row counter clears on four events
// - array bit selects mix, msb leftmost
// - low Y and X bits address pattern
// - even mask ignored while array enabled
// - mix select 01 picks masks or array
`timescale 1ns/1ps
`include "deicr_map.svh"
module deicr_regs (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_soft_rst,
    input wire logic i_io_wr,
    input wire logic [15:0] i_io_addr,
    input wire logic [15:0] i_io_wdata,
    output logic [15:0] o_io_rdata,
    input wire logic [3:0] i_read_index,
    input wire logic i_ext_one_wr,
    input wire logic i_cmd_start,
    input wire logic i_pattern_en,
    input wire logic i_flash_write_enable,
    input wire logic i_eight_plane_flag,
    input wire logic [1:0] i_mix_select,
    input wire deicr_pkg::deicr_pixel_t i_pix,
    output logic [11:0] o_rect_height,
    output deicr_pkg::deicr_clip_t o_clip,
    output logic [3:0] o_horiz_divisor,
    output logic [3:0] o_vert_banks_x2,
    output logic o_pseudo_eight_plane_mode,
    output logic o_upper_planes,
    output logic o_flash_write_cycle,
    output logic o_color_reg_cycle,
    output logic o_mix_valid,
    output logic o_mix_foreground
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [10:0] rect_height_count;
    deicr_pkg::deicr_clip_t clip;
    deicr_pkg::deicr_memcfg_t vram_layout_control;
    logic pseudo_eight_plane_mode;
    logic [4:0] pattern_even_mask;
    logic [4:0] pattern_odd_mask;
    logic [2:0] pattern_row;
    logic [15:0] rdata;

    logic [10:0] next_rect_height_count;
    deicr_pkg::deicr_clip_t next_clip;
    deicr_pkg::deicr_memcfg_t next_vram_layout_control;
    logic next_pseudo_eight_plane_mode;
    logic [4:0] next_pattern_even_mask;
    logic [4:0] next_pattern_odd_mask;
    logic [2:0] next_pattern_row;
    logic [15:0] next_rdata;

    logic port_wr;
    logic [3:0] wr_sel;
    logic [11:0] wr_data;
    logic pattern_wr;
    logic array_wr;
    logic [7:0] pattern_row_data;
    logic mix_fg;
    logic [11:0] next_height_out;
    logic [3:0] next_horiz_divisor;
    logic [3:0] next_vert_banks;
    logic next_upper_planes;
    logic next_flash_cycle;
    logic next_color_cycle;
    logic next_mix_valid;
    logic next_mix_fg;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] horiz_divisor(input logic [1:0] cfg);
        logic [3:0] d;
        d = 4'h4;
        case (cfg)
            2'h0: d = 4'h4;
            2'h1: d = 4'h5;
            2'h2: d = 4'h8;
            default: d = 4'hA;
        endcase
        return d;
    endfunction

    // twice the bank count, so half a bank stays integral
    function automatic logic [3:0] vert_banks_x2(input logic [1:0] cfg);
        logic [3:0] b;
        b = 4'h1;
        case (cfg)
            2'h0: b = 4'h1;
            2'h1: b = 4'h2;
            2'h2: b = 4'h4;
            default: b = 4'h8;
        endcase
        return b;
    endfunction

    // ----------------------------------------------------------------
    // host port
    // ----------------------------------------------------------------
    // split selector and data
    assign port_wr = i_io_wr && (i_io_addr == `DEICR_PORT_ADDR);
    assign wr_sel = i_io_wdata[`DEICR_SEL_HI:`DEICR_SEL_LO];
    assign wr_data = i_io_wdata[`DEICR_DATA_HI:0];
    assign pattern_wr = port_wr && (wr_sel == `DEICR_SEL_PAT_EVEN) && i_pattern_en;
    // clear events win over a coinciding array write
    assign array_wr = pattern_wr && !i_soft_rst && !i_ext_one_wr && !i_cmd_start;

    // ----------------------------------------------------------------
    // register next state
    // ----------------------------------------------------------------
    always_comb begin
        next_rect_height_count = rect_height_count;
        next_clip = clip;
        next_vram_layout_control = vram_layout_control;
        next_pseudo_eight_plane_mode = pseudo_eight_plane_mode;
        next_pattern_even_mask = pattern_even_mask;
        next_pattern_odd_mask = pattern_odd_mask;
        if (i_soft_rst) begin
            next_rect_height_count = '0;
            next_clip = '0;
            next_vram_layout_control = '0;
            next_pseudo_eight_plane_mode = 1'b0;
            next_pattern_even_mask = '0;
            next_pattern_odd_mask = '0;
        end else if (port_wr) begin
            if (wr_sel == `DEICR_SEL_HEIGHT) begin
                next_rect_height_count = wr_data[`DEICR_HEIGHT_HI:0];
            end else if (wr_sel == `DEICR_SEL_CLIP_TOP) begin
                next_clip.top = wr_data;
            end else if (wr_sel == `DEICR_SEL_CLIP_LEFT) begin
                next_clip.left = wr_data;
            end else if (wr_sel == `DEICR_SEL_CLIP_BOTTOM) begin
                next_clip.bottom = wr_data;
            end else if (wr_sel == `DEICR_SEL_CLIP_RIGHT) begin
                next_clip.right = wr_data;
            end else if (wr_sel == `DEICR_SEL_VRAM_LAYOUT) begin
                next_vram_layout_control.horiz_interleave_cfg = wr_data[`DEICR_HORIZ_LO +: 2];
                next_vram_layout_control.vert_bank_cfg = wr_data[`DEICR_VERT_LO +: 2];
                next_vram_layout_control.plane_buffer_select = wr_data[`DEICR_BUFSEL_BIT];
                next_vram_layout_control.color_reg_set_cycle = wr_data[`DEICR_COLOR_CYCLE_BIT];
                next_vram_layout_control.flash_write_select = wr_data[`DEICR_FLASH_SEL_BIT];
                if (wr_data[`DEICR_VERT_LO +: 2] != 2'h0) begin
                    next_pseudo_eight_plane_mode = 1'b0;
                end else if (!i_eight_plane_flag) begin
                    next_pseudo_eight_plane_mode = 1'b1;
                end
            end else if (wr_sel == `DEICR_SEL_PAT_EVEN) begin
                if (!i_pattern_en) begin
                    next_pattern_even_mask = wr_data[`DEICR_MASK_HI:0];
                end
            end else if (wr_sel == `DEICR_SEL_PAT_ODD) begin
                next_pattern_odd_mask = wr_data[`DEICR_MASK_HI:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rect_height_count <= '0;
            clip <= '0;
            vram_layout_control <= '0;
            pseudo_eight_plane_mode <= 1'b0;
            pattern_even_mask <= '0;
            pattern_odd_mask <= '0;
        end else begin
            rect_height_count <= next_rect_height_count;
            clip <= next_clip;
            vram_layout_control <= next_vram_layout_control;
            pseudo_eight_plane_mode <= next_pseudo_eight_plane_mode;
            pattern_even_mask <= next_pattern_even_mask;
            pattern_odd_mask <= next_pattern_odd_mask;
        end
    end

    // ----------------------------------------------------------------
    // pattern row counter
    // ----------------------------------------------------------------
    always_comb begin
        next_pattern_row = pattern_row;
        if (i_soft_rst || i_ext_one_wr || i_cmd_start) begin
            next_pattern_row = `DEICR_RESET_ROW;
        end else if (pattern_wr) begin
            next_pattern_row = pattern_row + 3'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pattern_row <= `DEICR_RESET_ROW;
        end else begin
            pattern_row <= next_pattern_row;
        end
    end

    // array contents survive reset; the row counter and the array read register clear
    // low Y bits pick array row
    deicr_pattern_mem #(
        .ROWS(8),
        .WIDTH(8)
    ) u_pattern_mem (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wr(array_wr),
        .i_wr_row(pattern_row),
        .i_wr_data(wr_data[`DEICR_ROW_HI:0]),
        .i_rd_row(i_pix.pix_y),
        .o_rd_data(pattern_row_data)
    );

    deicr_mix_pick u_mix_pick (
        .i_pattern_en(i_pattern_en),
        .i_even_mask(pattern_even_mask),
        .i_odd_mask(pattern_odd_mask),
        .i_row_data(pattern_row_data),
        .i_pix(i_pix),
        .o_foreground(mix_fg)
    );

    // ----------------------------------------------------------------
    // readback
    // ----------------------------------------------------------------
    always_comb begin
        next_rdata = 16'h0000;
        if (i_read_index == `DEICR_SEL_HEIGHT) begin
            next_rdata = {5'h00, rect_height_count};
        end else if (i_read_index == `DEICR_SEL_CLIP_TOP) begin
            next_rdata = {4'h0, clip.top};
        end else if (i_read_index == `DEICR_SEL_CLIP_LEFT) begin
            next_rdata = {4'h0, clip.left};
        end else if (i_read_index == `DEICR_SEL_CLIP_BOTTOM) begin
            next_rdata = {4'h0, clip.bottom};
        end else if (i_read_index == `DEICR_SEL_CLIP_RIGHT) begin
            next_rdata = {4'h0, clip.right};
        end else if (i_read_index == `DEICR_SEL_VRAM_LAYOUT) begin
            next_rdata = {9'h000, vram_layout_control.flash_write_select,
                vram_layout_control.color_reg_set_cycle, vram_layout_control.plane_buffer_select,
                vram_layout_control.vert_bank_cfg, vram_layout_control.horiz_interleave_cfg};
        end else if (i_read_index == `DEICR_SEL_PAT_EVEN) begin
            next_rdata = {11'h000, pattern_even_mask};
        end else if (i_read_index == `DEICR_SEL_PAT_ODD) begin
            next_rdata = {11'h000, pattern_odd_mask};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // derived controls
    // ----------------------------------------------------------------
    always_comb begin
        // drawn height is count plus one
        next_height_out = {1'b0, rect_height_count} + 12'h001;
        next_horiz_divisor = horiz_divisor(vram_layout_control.horiz_interleave_cfg);
        next_vert_banks = vert_banks_x2(vram_layout_control.vert_bank_cfg);
        // upper planes only in pseudo mode
        next_upper_planes = pseudo_eight_plane_mode && vram_layout_control.plane_buffer_select;
        next_flash_cycle = vram_layout_control.flash_write_select && i_flash_write_enable;
        next_color_cycle = vram_layout_control.color_reg_set_cycle && i_flash_write_enable;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rect_height <= `DEICR_RESET_HEIGHT_OUT;
            o_horiz_divisor <= `DEICR_RESET_HORIZ_DIV;
            o_vert_banks_x2 <= `DEICR_RESET_VERT_BANKS;
            o_upper_planes <= 1'b0;
            o_flash_write_cycle <= 1'b0;
            o_color_reg_cycle <= 1'b0;
        end else begin
            o_rect_height <= next_height_out;
            o_horiz_divisor <= next_horiz_divisor;
            o_vert_banks_x2 <= next_vert_banks;
            o_upper_planes <= next_upper_planes;
            o_flash_write_cycle <= next_flash_cycle;
            o_color_reg_cycle <= next_color_cycle;
        end
    end

    // ----------------------------------------------------------------
    // mix select
    // ----------------------------------------------------------------
    always_comb begin
        next_mix_valid = (i_mix_select == `DEICR_MIX_SELECT_PATTERN);
        next_mix_fg = next_mix_valid && mix_fg;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_mix_valid <= 1'b0;
            o_mix_foreground <= 1'b0;
        end else begin
            o_mix_valid <= next_mix_valid;
            o_mix_foreground <= next_mix_fg;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_io_rdata = rdata;
    assign o_clip = clip;
    assign o_pseudo_eight_plane_mode = pseudo_eight_plane_mode;
endmodule

// [logic/deicr_map.svh]
`ifndef DEICR_MAP_SVH
`define DEICR_MAP_SVH

`define DEICR_PORT_ADDR 16'hBEE8
`define DEICR_SEL_HI 15
`define DEICR_SEL_LO 12
`define DEICR_DATA_HI 11
`define DEICR_SEL_HEIGHT 4'h0
`define DEICR_SEL_CLIP_TOP 4'h1
`define DEICR_SEL_CLIP_LEFT 4'h2
`define DEICR_SEL_CLIP_BOTTOM 4'h3
`define DEICR_SEL_CLIP_RIGHT 4'h4
`define DEICR_SEL_VRAM_LAYOUT 4'h5
`define DEICR_SEL_PAT_EVEN 4'h8
`define DEICR_SEL_PAT_ODD 4'h9
`define DEICR_HEIGHT_HI 10
`define DEICR_HORIZ_LO 0
`define DEICR_VERT_LO 2
`define DEICR_BUFSEL_BIT 4
`define DEICR_COLOR_CYCLE_BIT 5
`define DEICR_FLASH_SEL_BIT 6
`define DEICR_MASK_HI 4
`define DEICR_ROW_HI 7
`define DEICR_MIX_SELECT_PATTERN 2'h1
`define DEICR_RESET_12 12'h000
`define DEICR_RESET_ROW 3'h0
`define DEICR_RESET_HEIGHT_OUT 12'h001
`define DEICR_RESET_HORIZ_DIV 4'h4
`define DEICR_RESET_VERT_BANKS 4'h1

`endif

// [logic/deicr_pkg.sv]
package deicr_pkg;

    typedef struct packed {
        logic [11:0] top;
        logic [11:0] left;
        logic [11:0] bottom;
        logic [11:0] right;
    } deicr_clip_t;

    typedef struct packed {
        logic [1:0] horiz_interleave_cfg;
        logic [1:0] vert_bank_cfg;
        logic plane_buffer_select;
        logic color_reg_set_cycle;
        logic flash_write_select;
    } deicr_memcfg_t;

    typedef struct packed {
        logic [2:0] pix_x;
        logic [2:0] pix_y;
        logic nugget_odd;
        logic [2:0] nugget_pos;
    } deicr_pixel_t;

endpackage

// [logic/deicr_pattern_mem.sv]
`timescale 1ns/1ps
module deicr_pattern_mem #(
    parameter int ROWS = 8,
    parameter int WIDTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wr,
    input wire logic [$clog2(ROWS)-1:0] i_wr_row,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic [$clog2(ROWS)-1:0] i_rd_row,
    output logic [WIDTH-1:0] o_rd_data
);
    logic [WIDTH-1:0] mem [ROWS];
    logic [WIDTH-1:0] next_rd_data;

    always_comb begin
        next_rd_data = mem[i_rd_row];
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= '0;
        end else begin
            o_rd_data <= next_rd_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_wr) begin
            mem[i_wr_row] <= i_wr_data;
        end
    end
endmodule

// [logic/deicr_mix_pick.sv]
`timescale 1ns/1ps
module deicr_mix_pick (
    input wire logic i_pattern_en,
    input wire logic [4:0] i_even_mask,
    input wire logic [4:0] i_odd_mask,
    input wire logic [7:0] i_row_data,
    input wire deicr_pkg::deicr_pixel_t i_pix,
    output logic o_foreground
);
    logic [4:0] mask;

    always_comb begin
        mask = i_pix.nugget_odd ? i_odd_mask : i_even_mask;
        if (i_pattern_en) begin
            o_foreground = i_row_data[3'h7 - i_pix.pix_x];
        end else if (i_pix.nugget_pos > 3'h4) begin
            o_foreground = 1'b0;
        end else begin
            o_foreground = mask[3'h4 - i_pix.nugget_pos];
        end
    end
endmodule

// [sim/deicr_regs_assertions.sv]
`timescale 1ns/1ps
`include "deicr_map.svh"
module deicr_regs_assertions (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_soft_rst,
    input wire logic i_io_wr,
    input wire logic [15:0] i_io_addr,
    input wire logic [15:0] i_io_wdata,
    input wire logic [3:0] i_read_index,
    input wire logic i_flash_write_enable,
    input wire logic [1:0] i_mix_select,
    input wire logic [15:0] o_io_rdata,
    input wire logic [11:0] o_rect_height,
    input wire deicr_pkg::deicr_clip_t o_clip,
    input wire logic o_pseudo_eight_plane_mode,
    input wire logic o_upper_planes,
    input wire logic o_flash_write_cycle,
    input wire logic o_color_reg_cycle,
    input wire logic o_mix_valid,
    input wire logic o_mix_foreground
);
    // ------------------------------------------------------------
    // port write, readback and output checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic wr_ok;
    logic [3:0] sel;
    assign wr_ok = i_io_wr && (i_io_addr == `DEICR_PORT_ADDR) && !i_soft_rst;
    assign sel = i_io_wdata[15:12];

    a_clip_top_write: assert property (wr_ok && sel == 4'h1 |=> o_clip.top == $past(i_io_wdata[11:0]))
        else $error("clip top not loaded");
    a_clip_right_write: assert property (wr_ok && sel == 4'h4 |=> o_clip.right == $past(i_io_wdata[11:0]))
        else $error("clip right not loaded");
    a_height_plus_one: assert property (wr_ok && sel == 4'h0 ##1 !i_soft_rst |=>
        o_rect_height == {1'b0, $past(i_io_wdata[10:0], 2)} + 12'h001)
        else $error("height is not count plus one");
    a_readback_index: assert property (i_read_index == 4'h2 && !i_soft_rst |=> o_io_rdata == {4'h0, $past(o_clip.left)})
        else $error("readback does not follow index");
    a_rdata_upper_zero: assert property (o_io_rdata[15:12] == 4'h0)
        else $error("readback upper bits not zero");
    a_unused_sel_ignored: assert property (wr_ok && sel == 4'h6 |=> $stable(o_clip))
        else $error("unused selector changed clip");
    a_pseudo_exit: assert property (wr_ok && sel == 4'h5 && i_io_wdata[3:2] != 2'h0 ##1 !i_soft_rst && !i_io_wr |=>
        !o_pseudo_eight_plane_mode)
        else $error("pseudo mode kept after nonzero vertical");
    a_upper_needs_pseudo: assert property (!o_pseudo_eight_plane_mode [*2] |-> !o_upper_planes)
        else $error("upper planes outside pseudo mode");
    a_flash_needs_enable: assert property (!i_flash_write_enable [*3] |-> !o_flash_write_cycle)
        else $error("flash cycle without enable");
    a_color_needs_enable: assert property (!i_flash_write_enable [*3] |-> !o_color_reg_cycle)
        else $error("colour cycle without enable");
    a_mix_select_gate: assert property ((i_mix_select != 2'h1) [*3] |-> !o_mix_valid && !o_mix_foreground)
        else $error("mix output without mix select");
endmodule

bind deicr_regs deicr_regs_assertions u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_soft_rst(i_soft_rst),
    .i_io_wr(i_io_wr), .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .i_read_index(i_read_index),
    .i_flash_write_enable(i_flash_write_enable), .i_mix_select(i_mix_select), .o_io_rdata(o_io_rdata),
    .o_rect_height(o_rect_height), .o_clip(o_clip), .o_pseudo_eight_plane_mode(o_pseudo_eight_plane_mode),
    .o_upper_planes(o_upper_planes), .o_flash_write_cycle(o_flash_write_cycle),
    .o_color_reg_cycle(o_color_reg_cycle), .o_mix_valid(o_mix_valid), .o_mix_foreground(o_mix_foreground));

// [sim/deicr_regs_tb.sv]
`timescale 1ns/1ps
`include "deicr_map.svh"
module deicr_regs_tb;
    logic i_clk, i_rst_n, i_soft_rst, i_io_wr, i_ext_one_wr, i_cmd_start, i_pattern_en;
    logic i_flash_write_enable, i_eight_plane_flag, o_pseudo_eight_plane_mode, o_upper_planes;
    logic o_flash_write_cycle, o_color_reg_cycle, o_mix_valid, o_mix_foreground;
    logic [15:0] i_io_addr, i_io_wdata, o_io_rdata;
    logic [3:0] i_read_index, o_horiz_divisor, o_vert_banks_x2;
    logic [1:0] i_mix_select;
    logic [11:0] o_rect_height;
    deicr_pkg::deicr_pixel_t i_pix;
    deicr_pkg::deicr_clip_t o_clip;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;

    deicr_regs dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_soft_rst(i_soft_rst), .i_io_wr(i_io_wr),
        .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .i_read_index(i_read_index),
        .i_ext_one_wr(i_ext_one_wr), .i_cmd_start(i_cmd_start), .i_pattern_en(i_pattern_en),
        .i_flash_write_enable(i_flash_write_enable), .i_eight_plane_flag(i_eight_plane_flag),
        .i_mix_select(i_mix_select), .i_pix(i_pix), .o_rect_height(o_rect_height), .o_clip(o_clip),
        .o_horiz_divisor(o_horiz_divisor), .o_vert_banks_x2(o_vert_banks_x2),
        .o_pseudo_eight_plane_mode(o_pseudo_eight_plane_mode), .o_upper_planes(o_upper_planes),
        .o_flash_write_cycle(o_flash_write_cycle), .o_color_reg_cycle(o_color_reg_cycle),
        .o_mix_valid(o_mix_valid), .o_mix_foreground(o_mix_foreground));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_io_addr <= a;
        i_io_wdata <= d;
        i_io_wr <= 1'b1;
        @(posedge i_clk);
        i_io_wr <= 1'b0;
        wt(3);
    endtask
    task automatic rd(input logic [3:0] idx, input logic [15:0] exp);
        @(posedge i_clk);
        i_read_index <= idx;
        wt(2);
        chk("readback", o_io_rdata, exp);
    endtask
    task automatic px(input logic [2:0] x, input logic [2:0] y, input logic odd, input logic [2:0] pos,
        input logic exp);
        @(posedge i_clk);
        i_pix <= {x, y, odd, pos};
        wt(3);
        chk("foreground", {15'h0, o_mix_foreground}, {15'h0, exp});
    endtask
    // k 0: extension write, 1: command start, 2: soft reset with a clashing write
    task automatic pulse(input int k);
        @(posedge i_clk);
        i_ext_one_wr <= (k == 0);
        i_cmd_start <= (k == 1);
        i_soft_rst <= (k == 2);
        i_io_addr <= `DEICR_PORT_ADDR;
        i_io_wdata <= 16'h1FFF;
        i_io_wr <= (k == 2);
        @(posedge i_clk);
        i_ext_one_wr <= 1'b0;
        i_cmd_start <= 1'b0;
        i_soft_rst <= 1'b0;
        i_io_wr <= 1'b0;
        wt(3);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk("height", {4'h0, o_rect_height}, 16'h0001);
        chk("divisor", {12'h0, o_horiz_divisor, o_vert_banks_x2}, 16'h0041);
        chk("clip", o_clip.top | o_clip.left | o_clip.bottom | o_clip.right, 16'h0000);
    endtask
    task automatic t_subregs();
        for (int s = 0; s < 5; s++) begin
            wr(`DEICR_PORT_ADDR, {s[3:0], 12'hC3A + 12'(s)});
            rd(s[3:0], (s == 0) ? 16'h043A : {4'h0, 12'hC3A + 12'(s)});
        end
        chk("height", {4'h0, o_rect_height}, 16'h043B);
        chk("top", {4'h0, o_clip.top}, 16'h0C3B);
        chk("left", {4'h0, o_clip.left}, 16'h0C3C);
        chk("bottom", {4'h0, o_clip.bottom}, 16'h0C3D);
        chk("right", {4'h0, o_clip.right}, 16'h0C3E);
        wr(`DEICR_PORT_ADDR, 16'h6FFF);
        wr(`DEICR_PORT_ADDR, 16'hFFFF);
        wr(16'hBEEA, 16'h1000);
        rd(4'h1, 16'h0C3B);
    endtask
    task automatic t_memcfg();
        logic [3:0] div [4] = '{4'h4, 4'h5, 4'h8, 4'hA};
        for (int i = 0; i < 4; i++) begin
            wr(`DEICR_PORT_ADDR, {4'h5, 8'h00, 2'(i), 2'(i)});
            chk("horiz", {12'h0, o_horiz_divisor}, {12'h0, div[i]});
            chk("banks", {12'h0, o_vert_banks_x2}, 16'h0001 << i);
            rd(4'h5, {12'h0, 2'(i), 2'(i)});
        end
    endtask
    task automatic t_pseudo();
        @(posedge i_clk);
        i_eight_plane_flag <= 1'b0;
        wr(`DEICR_PORT_ADDR, 16'h5010);
        chk("pseudo", {14'h0, o_pseudo_eight_plane_mode, o_upper_planes}, 16'h0003);
        @(posedge i_clk);
        i_eight_plane_flag <= 1'b1;
        wr(`DEICR_PORT_ADDR, 16'h5000);
        chk("pseudo", {14'h0, o_pseudo_eight_plane_mode, o_upper_planes}, 16'h0002);
        wr(`DEICR_PORT_ADDR, 16'h5014);
        chk("pseudo", {14'h0, o_pseudo_eight_plane_mode, o_upper_planes}, 16'h0000);
    endtask
    task automatic t_flash();
        wr(`DEICR_PORT_ADDR, 16'h5064);
        chk("flash", {14'h0, o_flash_write_cycle, o_color_reg_cycle}, 16'h0000);
        @(posedge i_clk);
        i_flash_write_enable <= 1'b1;
        wt(3);
        chk("flash", {14'h0, o_flash_write_cycle, o_color_reg_cycle}, 16'h0003);
        wr(`DEICR_PORT_ADDR, 16'h5044);
        chk("flash", {14'h0, o_flash_write_cycle, o_color_reg_cycle}, 16'h0002);
    endtask
    task automatic t_masks();
        @(posedge i_clk);
        i_mix_select <= 2'h1;
        wr(`DEICR_PORT_ADDR, 16'h8010);
        wr(`DEICR_PORT_ADDR, 16'h9001);
        px(3'h0, 3'h0, 1'b0, 3'h0, 1'b1);
        px(3'h0, 3'h0, 1'b0, 3'h4, 1'b0);
        px(3'h0, 3'h0, 1'b1, 3'h4, 1'b1);
        px(3'h0, 3'h0, 1'b1, 3'h0, 1'b0);
        px(3'h0, 3'h0, 1'b0, 3'h5, 1'b0);
        chk("valid", {15'h0, o_mix_valid}, 16'h0001);
        @(posedge i_clk);
        i_mix_select <= 2'h2;
        px(3'h0, 3'h0, 1'b0, 3'h0, 1'b0);
        chk("valid", {15'h0, o_mix_valid}, 16'h0000);
        @(posedge i_clk);
        i_mix_select <= 2'h1;
    endtask
    task automatic t_pattern();
        @(posedge i_clk);
        i_pattern_en <= 1'b1;
        wr(`DEICR_PORT_ADDR, 16'h80FF);
        pulse(0);
        for (int r = 0; r < 8; r++) wr(`DEICR_PORT_ADDR, {8'h80, 8'h80 >> r});
        for (int r = 0; r < 8; r++) begin
            px(3'(r), 3'(r), 1'b0, 3'h0, 1'b1);
            px(3'(r + 1), 3'(r), 1'b1, 3'h4, 1'b0);
        end
        rd(4'h8, 16'h0010);
    endtask
    task automatic t_counter_clear();
        wr(`DEICR_PORT_ADDR, 16'h80FF);
        pulse(1);
        wr(`DEICR_PORT_ADDR, 16'h8000);
        px(3'h0, 3'h0, 1'b0, 3'h0, 1'b0);
        px(3'h1, 3'h1, 1'b0, 3'h0, 1'b1);
        wr(`DEICR_PORT_ADDR, 16'h80FF);
        pulse(2);
        chk("top", {4'h0, o_clip.top}, 16'h0000);
        wr(`DEICR_PORT_ADDR, 16'h807F);
        px(3'h1, 3'h0, 1'b0, 3'h0, 1'b1);
        px(3'h0, 3'h0, 1'b0, 3'h0, 1'b0);
        wr(`DEICR_PORT_ADDR, 16'h80FF);
        wr(`DEICR_PORT_ADDR, 16'h5064);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        wt(1);
        chk("flash", {14'h0, o_flash_write_cycle, o_color_reg_cycle}, 16'h0000);
        wr(`DEICR_PORT_ADDR, 16'h8080);
        px(3'h0, 3'h0, 1'b0, 3'h0, 1'b1);
    endtask

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    task automatic complete_run();
        if (num_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        {i_rst_n, i_soft_rst, i_io_wr, i_ext_one_wr, i_cmd_start, i_pattern_en} = 6'h00;
        {i_flash_write_enable, i_eight_plane_flag, i_mix_select, i_read_index} = 8'h40;
        i_io_addr = 16'h0000;
        i_io_wdata = 16'h0000;
        i_pix = '0;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        wt(1);
        t_reset();
        t_subregs();
        t_memcfg();
        t_pseudo();
        t_flash();
        t_masks();
        t_pattern();
        t_counter_clear();
        complete_run();
    end
endmodule
